// [logic/pmtc_cfg.svh]
/*
 * constants for the mac-facing clock and transmit block.
 * assumes a 50 mhz core clock equal to the rmii reference.
 */
`ifndef PMTC_CFG_SVH
`define PMTC_CFG_SVH

// core clock rate in hz
`define PMTC_CORE_HZ 50000000
// line clock rates in hz per speed mode
`define PMTC_HZ_100X 25000000
`define PMTC_HZ_10MII 2500000
`define PMTC_HZ_10SER 10000000
// width of the half-period counters
`define PMTC_CNT_W 5
// forced-error and idle 5b code groups
`define PMTC_CODE_TXERR 5'h04
`define PMTC_CODE_IDLE 5'h1f
// serial mode data bit
`define PMTC_SER_BIT 0

`endif

// [logic/pmtc_clkdiv.sv]
/*
 * clock divider: drives a clock level and a rising-edge pulse.
 * assumes hi_cyc and lo_cyc are at least one.
 */
`timescale 1ns/1ps
`include "pmtc_cfg.svh"

module pmtc_clkdiv
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic [`PMTC_CNT_W-1:0] hi_cyc_i,
  input wire logic [`PMTC_CNT_W-1:0] lo_cyc_i,
  output logic clk_o,
  output logic rise_o
);
  logic [`PMTC_CNT_W-1:0] cnt_reg;
  logic [`PMTC_CNT_W-1:0] hi_m1;
  logic [`PMTC_CNT_W-1:0] lo_m1;

  // reload values for each half period
  assign hi_m1 = hi_cyc_i - `PMTC_CNT_W'(1);
  assign lo_m1 = lo_cyc_i - `PMTC_CNT_W'(1);

  // restart begins a fresh low phase, cutting a running high phase short or stretching a low one
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      clk_o <= 1'b0;
      rise_o <= 1'b0;
      cnt_reg <= '0;
    end
    else if (restart_i)
    begin
      clk_o <= 1'b0;
      rise_o <= 1'b0;
      cnt_reg <= lo_m1;
    end
    else if (cnt_reg == '0)
    begin
      clk_o <= ~clk_o;
      rise_o <= ~clk_o;
      cnt_reg <= clk_o ? lo_m1 : hi_m1;
    end
    else
    begin
      rise_o <= 1'b0;
      cnt_reg <= cnt_reg - `PMTC_CNT_W'(1);
    end
  end
endmodule

// [logic/pmtc_pkg.sv]
/*
 * types for the mac-facing clock and transmit block.
 * assumes nothing beyond the cfg header.
 */
package pmtc_pkg;
  // speed mode as given by the straps
  typedef enum logic [1:0] {
    PMTC_100X,
    PMTC_10_MII,
    PMTC_10_SER
  } pmtc_speed_t;
endpackage

// [logic/pmtc_top.sv]
/*
 * mac-facing side of a 10/100 transceiver: transmit and receive clock
 * generation, transmit data capture in mii, rmii and serial modes,
 * 5b code output for 100 mbit mii, receive data valid and clock realign.
 * assumes core_clk_i is the 50 mhz local reference; all pin inputs
 * are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`include "pmtc_cfg.svh"

module pmtc_top
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic rmii_mode_i,
  input wire logic [1:0] speed_mode_i,
  input wire logic [3:0] txd_i,
  input wire logic tx_en_i,
  input wire logic tx_er_i,
  input wire logic line_frame_i,
  output logic txc_o,
  output logic rxc_o,
  output logic rx_dv_o,
  output logic [3:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_err_o,
  output logic [4:0] tx_code_o
);
  localparam int CW = `PMTC_CNT_W;

  // two-stage synchronisers for every pin input
  logic [9:0] pin_meta_reg;
  logic [9:0] pin_sync_reg;
  logic [9:0] pin_raw;
  assign pin_raw = {rmii_mode_i, speed_mode_i, txd_i, tx_en_i, tx_er_i,
    line_frame_i};

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // named views of the synchronised pins
  logic rmii_s;
  logic [1:0] speed_raw;
  logic [3:0] txd_s;
  logic tx_en_s;
  logic tx_er_s;
  logic frame_s;
  pmtc_pkg::pmtc_speed_t speed_s;
  assign rmii_s = pin_sync_reg[9];
  assign speed_raw = pin_sync_reg[8:7];
  assign txd_s = pin_sync_reg[6:3];
  assign tx_en_s = pin_sync_reg[2];
  assign tx_er_s = pin_sync_reg[1];
  assign frame_s = pin_sync_reg[0];
  // the unused strap code falls back to 100 mbit
  assign speed_s = (speed_raw == 2'h3) ? pmtc_pkg::PMTC_100X
    : pmtc_pkg::pmtc_speed_t'(speed_raw);

  // clock period in core cycles for a speed mode
  function automatic logic [CW-1:0] period_cyc(
    input pmtc_pkg::pmtc_speed_t sp);
    logic [CW-1:0] p;
    p = CW'(`PMTC_CORE_HZ / `PMTC_HZ_100X);
    unique case (sp)
      pmtc_pkg::PMTC_100X: p = CW'(`PMTC_CORE_HZ / `PMTC_HZ_100X);
      pmtc_pkg::PMTC_10_MII: p = CW'(`PMTC_CORE_HZ / `PMTC_HZ_10MII);
      pmtc_pkg::PMTC_10_SER: p = CW'(`PMTC_CORE_HZ / `PMTC_HZ_10SER);
    endcase
    return p;
  endfunction

  // 4b to 5b data code group
  function automatic logic [4:0] enc_4b5b(input logic [3:0] n);
    logic [4:0] c;
    c = 5'h1e;
    unique case (n)
      4'h0: c = 5'h1e;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0a;
      4'h5: c = 5'h0b;
      4'h6: c = 5'h0e;
      4'h7: c = 5'h0f;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'ha: c = 5'h16;
      4'hb: c = 5'h17;
      4'hc: c = 5'h1a;
      4'hd: c = 5'h1b;
      4'he: c = 5'h1c;
      4'hf: c = 5'h1d;
    endcase
    return c;
  endfunction

  // half periods; odd periods put the extra cycle in the low phase
  logic [CW-1:0] per;
  logic [CW-1:0] hi_cyc;
  logic [CW-1:0] lo_cyc;
  assign per = period_cyc(speed_s);
  assign hi_cyc = per >> 1;
  assign lo_cyc = per - hi_cyc;

  logic txc_lvl;
  logic txc_rise;
  pmtc_clkdiv u_tx_div
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .restart_i(1'b0),
    .hi_cyc_i(hi_cyc),
    .lo_cyc_i(lo_cyc),
    .clk_o(txc_lvl),
    .rise_o(txc_rise)
  );

  // receive side: packet start seen as a rising frame level
  logic frame_d_reg;
  logic pkt_start;
  logic rx_restart;
  logic rxc_lvl;
  logic rxc_rise;
  assign pkt_start = frame_s & ~frame_d_reg;
  // realign only while data valid is low
  assign rx_restart = pkt_start & ~rx_dv_o;

  pmtc_clkdiv u_rx_div
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .restart_i(rx_restart),
    .hi_cyc_i(hi_cyc),
    .lo_cyc_i(lo_cyc),
    .clk_o(rxc_lvl),
    .rise_o(rxc_rise)
  );

  // clock pins copy the divider levels one flop later
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      txc_o <= 1'b0;
      rxc_o <= 1'b0;
      frame_d_reg <= 1'b0;
    end
    else
    begin
      txc_o <= txc_lvl;
      rxc_o <= rxc_lvl;
      frame_d_reg <= frame_s;
    end
  end

  // data valid follows the frame on receive clock rising edges
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      rx_dv_o <= 1'b0;
    else if (rxc_rise)
      rx_dv_o <= frame_s;
  end

  // transmit capture: rmii samples every reference cycle
  logic tx_strobe;
  logic [3:0] txd_q;
  logic [4:0] code_next;
  assign tx_strobe = rmii_s ? 1'b1 : txc_rise;
  // rmii idle dibit forced to 00; serial keeps bit 0
  assign txd_q = rmii_s ? (tx_en_s ? {2'h0, txd_s[1:0]} : 4'h0)
    : (speed_s == pmtc_pkg::PMTC_10_SER)
    ? {3'h0, txd_s[`PMTC_SER_BIT]} : txd_s;
  // error request replaces the data code group
  assign code_next = !tx_en_s ? `PMTC_CODE_IDLE
    : tx_er_s ? `PMTC_CODE_TXERR : enc_4b5b(txd_q);

  // inputs taken on the transmit clock rise, or every reference cycle in rmii mode
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      tx_data_o <= 4'h0;
      tx_valid_o <= 1'b0;
      tx_err_o <= 1'b0;
      tx_code_o <= `PMTC_CODE_IDLE;
    end
    else if (tx_strobe)
    begin
      tx_data_o <= txd_q;
      tx_valid_o <= tx_en_s;
      tx_err_o <= tx_er_s;
      // 5b codes only mean something at 100 mbit in mii mode
      tx_code_o <= (speed_s == pmtc_pkg::PMTC_100X && !rmii_s)
        ? code_next : `PMTC_CODE_IDLE;
    end
  end
endmodule

// [verification/pmtc_checker.sv]
/* port checker for pmtc_top.
   assumes straps stay put for a while after each change. */
`timescale 1ns/1ps
module pmtc_checker (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic rmii_mode_i,
  input wire logic [1:0] speed_mode_i,
  input wire logic line_frame_i,
  input wire logic txc_o,
  input wire logic rxc_o,
  input wire logic rx_dv_o,
  input wire logic [3:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_err_o,
  input wire logic [4:0] tx_code_o
);
  logic [3:0] age_reg;
  logic [2:0] strap_reg;
  logic ok;
  logic s0;
  // strap age; syncs and dividers settle first
  always_ff @(posedge core_clk_i)
  begin
    strap_reg <= {rmii_mode_i, speed_mode_i};
    if (rst_i || strap_reg != {rmii_mode_i, speed_mode_i})
      age_reg <= 4'h0;
    else if (!ok)
      age_reg <= age_reg + 4'h1;
  end
  // drops in the very cycle a strap moves, not one edge later
  assign ok = age_reg == 4'hf && strap_reg == {rmii_mode_i, speed_mode_i};
  assign s0 = ok && speed_mode_i == 2'h0;
  default clocking @(posedge core_clk_i); endclocking
  // a strap change mid-period aborts clock checks already in flight
  default disable iff (rst_i || !ok);
  AST_TXC_FAST: assert property (
    s0 |-> txc_o != $past(txc_o)) else $error("txc fast");
  AST_TXC_SER: assert property (
    ok && speed_mode_i == 2'h2 && $rose(txc_o)
    |=> txc_o ##1 !txc_o [*3] ##1 txc_o) else $error("txc ser");
  AST_TXC_MII: assert property (
    ok && speed_mode_i == 2'h1 && $rose(txc_o)
    |-> ##10 $fell(txc_o) ##10 $rose(txc_o)) else $error("txc mii");
  AST_RMII_IDLE: assert property (
    ok && rmii_mode_i && !tx_valid_o |-> tx_data_o == 4'h0)
    else $error("rmii idle");
  AST_SER_BIT: assert property (
    ok && !rmii_mode_i && speed_mode_i == 2'h2
    |-> tx_data_o[3:1] == 3'h0) else $error("ser bits");
  AST_TX_ERR: assert property (
    s0 && !rmii_mode_i && tx_valid_o && tx_err_o
    |-> tx_code_o == 5'h04) else $error("err code");
  AST_RX_STEADY: assert property (
    s0 && rx_dv_o && $past(rx_dv_o) |-> rxc_o != $past(rxc_o))
    else $error("rxc stretch");
  AST_RX_VALID: assert property (
    ok && $rose(line_frame_i) |-> ##[1:40] rx_dv_o)
    else $error("no dv");
endmodule
bind pmtc_top pmtc_checker CHK (.*);

// [verification/pmtc_mac_model.sv]
/* mac model: counting nibble stream, garbage when idle.
   assumes txc_i is the block's transmit clock. */
`timescale 1ns/1ps
module pmtc_mac_model (
  input wire logic clk_i,
  input wire logic rmii_i,
  input wire logic txc_i,
  input wire logic send_i,
  input wire logic err_i,
  output logic [3:0] txd_o = 4'h0,
  output logic tx_en_o = 1'b0,
  output logic tx_er_o = 1'b0
);
  logic txc_reg = 1'b0;
  logic step;
  // rmii steps every cycle, mii on txc rise
  assign step = rmii_i || (txc_i && !txc_reg);
  always_ff @(posedge clk_i)
  begin
    txc_reg <= txc_i;
    if (step)
    begin
      tx_en_o <= send_i;
      tx_er_o <= send_i && err_i;
      txd_o <= send_i ? txd_o + 4'h1 : ~txd_o;
    end
  end
endmodule

// [verification/test_phy_mii_rmii_tx_clocking.sv]
/* bench for pmtc_top with a mac model.
   assumes the checker is bound in. */
`timescale 1ns/1ps
module test_phy_mii_rmii_tx_clocking;
  logic clk = 0, rst = 1, rmii = 0, frame = 0, send = 0, err = 0;
  logic [1:0] spd = 2'h0;
  logic [3:0] txd, dat;
  logic en, er, txc, rxc, dv, val, terr;
  logic [4:0] code, p;
  int bad_count = 0, n_checks = 0;
  always #10 clk = ~clk;
  pmtc_top DUT (.core_clk_i(clk), .rst_i(rst), .rmii_mode_i(rmii),
    .speed_mode_i(spd), .txd_i(txd), .tx_en_i(en), .tx_er_i(er),
    .line_frame_i(frame), .txc_o(txc), .rxc_o(rxc), .rx_dv_o(dv),
    .tx_data_o(dat), .tx_valid_o(val), .tx_err_o(terr),
    .tx_code_o(code));
  pmtc_mac_model MAC (.clk_i(clk), .rmii_i(rmii), .txc_i(txc),
    .send_i(send), .err_i(err), .txd_o(txd), .tx_en_o(en),
    .tx_er_o(er));
  task chk(string n, logic [4:0] e, logic [4:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // sample on negedge, clear of register updates
  task cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  function logic lv(bit rx);
    return rx ? rxc : txc;
  endfunction
  task automatic hold(ref logic s, input logic v);
    for (int i = 0; i < 40 && s !== v; i++) cyc(1);
  endtask
  // one full period from a rise; bounded so a stuck clock shows
  task period(bit rx);
    int i;
    for (i = 0; i < 40 && lv(rx); i++) cyc(1);
    for (i = 0; i < 40 && !lv(rx); i++) cyc(1);
    for (i = 0; i < 40 && lv(rx); i++) cyc(1);
    p = i[4:0];
    for (i = 0; i < 40 && !lv(rx); i++) cyc(1);
    p = p + i[4:0];
  endtask
  task automatic t_clocks;
    logic [4:0] want [3] = '{5'h02, 5'h14, 5'h05};
    for (int s = 0; s < 3; s++)
    begin
      @(posedge clk) spd <= s[1:0];
      cyc(30);
      period(0);
      chk("txc period", want[s], p);
      period(1);
      chk("rxc period", want[s], p);
    end
    $display("clock test done");
  endtask
  task automatic t_err;
    // 4b to 5b data code groups, nibble value as index
    logic [4:0] grp [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
      5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c,
      5'h1d};
    @(posedge clk);
    spd <= 2'h0;
    send <= 1'b1;
    err <= 1'b1;
    cyc(20);
    chk("valid", 5'h01, {4'h0, val});
    chk("error flag", 5'h01, {4'h0, terr});
    chk("error code", 5'h04, code);
    @(posedge clk);
    err <= 1'b0;
    // model step, sync and strobe take up to six edges
    cyc(8);
    repeat (3)
    begin
      cyc(3);
      chk("data code", grp[dat], code);
    end
    @(posedge clk);
    send <= 1'b0;
    cyc(20);
    chk("error flag", 5'h00, {4'h0, terr});
    chk("idle code", 5'h1f, code);
    $display("error test done");
  endtask
  task t_rmii;
    @(posedge clk);
    rmii <= 1'b1;
    cyc(20);
    chk("rmii idle", 5'h00, {1'b0, dat});
    @(posedge clk);
    send <= 1'b1;
    cyc(6);
    chk("rmii valid", 5'h01, {4'h0, val});
    chk("rmii upper", 5'h00, {3'h0, dat[3:2]});
    @(posedge clk);
    send <= 1'b0;
    rmii <= 1'b0;
    $display("rmii test done");
  endtask
  task t_ser;
    @(posedge clk);
    spd <= 2'h2;
    send <= 1'b1;
    cyc(30);
    repeat (4)
    begin
      cyc(5);
      chk("serial upper", 5'h00, {2'h0, dat[3:1]});
    end
    @(posedge clk);
    send <= 1'b0;
    $display("serial test done");
  endtask
  task t_rx;
    @(posedge clk);
    spd <= 2'h0;
    // let the strap settle so the checker watches the frame start
    cyc(20);
    @(posedge clk);
    frame <= 1'b1;
    hold(dv, 1'b1);
    chk("dv rise", 5'h01, {4'h0, dv});
    period(1);
    chk("rxc in frame", 5'h02, p);
    @(posedge clk);
    frame <= 1'b0;
    hold(dv, 1'b0);
    chk("dv fall", 5'h00, {4'h0, dv});
    $display("receive test done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cyc(5);
    t_clocks;
    t_err;
    t_rmii;
    t_ser;
    t_rx;
    print_verdict;
  end
  // watchdog; the tests need well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    print_verdict;
  end
endmodule
